// ---- core/vcc_map.svh ----
/*
 * Register offsets, field positions, command codes and bus response codes of the
 * video control command/status block.
 * Assumes an AXI4-Lite slave with 32-bit data and byte addresses.
 */
// Summary of operation
// - cursor address is 14 bits; upper byte holds six bits, top two unused.
// - primary row-start upper top bits read zero; optionally copied to size attr.
// - secondary upper bit 7 reloads split B, bit 6 split A; both read zero.
// - a set flag stays set until flag-reset command, master reset or reset.
// - idle flag is status bit 5 only, one after master reset; 7:6 zero.
// - frame blank flag, bit 4, sets at first front porch line.
// - line-zero flag, bit 3, sets at line 0 of each active row.
// - split A flag, bit 2, sets when row equals split A value at line 0.
// - ready flag, bit 1, sets when a delayed command ends; master reset clears.
// - split B flag, bit 0, matches split B value, plus one while scrolling.
// - command byte decoded on write; instant commands other than master reset leave idle alone and never set ready.
// - master reset holds syncs low for one cycle, blank high until display-on.
// - master reset clears flags and masks, sets idle, modes off, pointer zero.
// - load-pointer presets pointer from low four bits; only 0 to 14.
// - graphics addressing starts and stops at the next row boundary.
// - line-graphics strobe at blank trailing edge while graphics active.
// - display-off forces blank; bit 2 also floats the display address bus.
// - display-on resumes blank at next field or line; drivers back on.
// - cursor-off holds cursor low; cursor-on restores it.
// - flag-reset clears flags selected by ones in its low five bits.
// - disable/enable interrupt clear/set selected mask bits, same mapping.
// - unmasked event sets masked flag and interrupt; masked event neither.
// - raw status records every event regardless of masks.
`ifndef VCC_MAP_SVH
`define VCC_MAP_SVH

// register byte offsets
`define VCC_A_CMD 8'h00
`define VCC_A_CUR_HI 8'h04
`define VCC_A_CUR_LO 8'h08
`define VCC_A_PRS_HI 8'h0C
`define VCC_A_PRS_LO 8'h10
`define VCC_A_SRS_HI 8'h14
`define VCC_A_SRS_LO 8'h18
`define VCC_A_EV_MASKED 8'h1C
`define VCC_A_EV_RAW 8'h20
`define VCC_A_MODE 8'h24

// fields
`define VCC_B_SPLIT_B_RELOAD 7
`define VCC_B_SPLIT_A_RELOAD 6
`define VCC_B_CMD_N 2
`define VCC_B_CMD_ON 0
`define VCC_B_CMD_GFX 1
`define VCC_B_CMD_DSP 3
`define VCC_B_CMD_CUR 4
`define VCC_PTR_MAX 4'hE

// command code groups, top bits
`define VCC_CMD_MRESET 8'h00
`define VCC_OP4_LOAD_PTR 4'h1
`define VCC_OP3_MODE 3'h1
`define VCC_OP3_FLAG_CLR 3'h2
`define VCC_OP3_INT_EN 3'h3
`define VCC_OP3_INT_DIS 3'h4
`define VCC_OP3_DELAYED 3'h5

// bus answers
`define VCC_RESP_OKAY 2'h0
`define VCC_RESP_SLVERR 2'h2

`endif

// ---- core/vcc_pkg.sv ----
/*
 * Types of the video control command/status block.
 * Assumes vcc_map.svh supplies all numeric constants.
 */
package vcc_pkg;

    // whole state of the block, registered as one word
    typedef struct packed {
        logic aw_got;
        logic w_got;
        logic [7:0] waddr;
        logic [7:0] wdata;
        logic wlane0;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic [5:0] cur_hi;
        logic [7:0] cur_lo;
        logic [5:0] prs_hi;
        logic [7:0] prs_lo;
        logic [5:0] srs_hi;
        logic [7:0] srs_lo;
        logic split_a_reload;
        logic split_b_reload;
        logic [1:0] row_size;
        logic [4:0] raw;
        logic [4:0] masked;
        logic [4:0] mask;
        logic idle;
        logic [3:0] pointer;
        logic gfx_req;
        logic gfx_active;
        logic cursor_en;
        logic blank_force;
        logic resume_pend;
        logic resume_field;
        logic addr_oe;
        logic lg_strobe;
        logic mr_pulse;
        logic [1:0] mr_count;
        logic por_released;
    } vcc_state_s;

endpackage

// ---- core/vcc_top.sv ----
/*
 * Command decoder and event flag logic of a display controller, reached
 * over AXI4-Lite. Timing events arrive as one-cycle pulses from the sync
 * generator running on the same clock; the delayed command engine reports
 * completion on delayed_done.
 */
`include "vcc_map.svh"

module vcc_top
    import vcc_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // timing events from the raster generator
    input wire logic frame_blank_flag_start,
    input wire logic row_line0,
    input wire logic [6:0] row_number,
    input wire logic scrolling,
    input wire logic line_start,
    input wire logic field_start,
    input wire logic row_start,
    input wire logic blank_fall,
    input wire logic delayed_done,
    // initialization words
    input wire logic init_word_zero_bit7,
    input wire logic [6:0] split_row_a_value,
    input wire logic [6:0] split_row_b_value,
    // control outputs
    output logic host_interrupt_out,
    output logic blank_force,
    output logic sync_hold_low,
    output logic display_address_oe,
    output logic cursor_enable,
    output logic graphics_active,
    output logic line_graphics_strobe,
    output logic [3:0] init_word_pointer,
    output logic init_word_two_clear,
    output logic [1:0] row_size_attr_field,
    output logic split_a_reload_enable,
    output logic split_b_reload_enable,
    output logic [13:0] cursor_position,
    output logic [13:0] primary_row_start,
    output logic [13:0] secondary_row_start,
    output logic por_released
);

    // register map lookup, used by both read and write paths
    function automatic logic addr_known(input logic [7:0] a);
        case (a)
            `VCC_A_CMD, `VCC_A_CUR_HI, `VCC_A_CUR_LO,
            `VCC_A_PRS_HI, `VCC_A_PRS_LO, `VCC_A_SRS_HI,
            `VCC_A_SRS_LO, `VCC_A_EV_MASKED, `VCC_A_EV_RAW,
            `VCC_A_MODE: addr_known = 1'b1;
            default: addr_known = 1'b0;
        endcase
    endfunction

    // split compare at line zero of a row
    function automatic logic row_hit(input logic [6:0] row,
                                     input logic [6:0] target);
        row_hit = (row == target);
    endfunction

    vcc_state_s st_r;
    vcc_state_s st_nxt;
    logic do_wr;
    logic cmd_fire;
    logic [7:0] cmd;
    logic [4:0] ev;
    logic [4:0] clr;
    logic mr_fire;
    logic [6:0] split_b_target;

    // handshake readiness: one write and one read in flight at a time
    assign s_axi_awready = !st_r.aw_got && !st_r.bvalid;
    assign s_axi_wready = !st_r.w_got && !st_r.bvalid;
    assign s_axi_arready = !st_r.rvalid;

    // write executes once both halves are held
    assign do_wr = st_r.aw_got && st_r.w_got && !st_r.bvalid;
    assign cmd = st_r.wdata;
    assign cmd_fire = do_wr && st_r.wlane0 && st_r.waddr == `VCC_A_CMD;
    assign mr_fire = cmd_fire && cmd == `VCC_CMD_MRESET;

    // scrolling shifts the split B match one row down
    assign split_b_target = scrolling ? 7'(split_row_b_value + 7'h01)
                                      : split_row_b_value;

    // events in flag order {frame_blank_flag, line0, split a, ready, split b}
    assign ev = {frame_blank_flag_start,
                 row_line0,
                 row_line0 && row_hit(row_number, split_row_a_value),
                 delayed_done,
                 row_line0 && row_hit(row_number, split_b_target)};

    // flag-reset selection; master reset clears all
    always_comb begin
        if (mr_fire)
            clr = 5'h1F;
        else if (cmd_fire && cmd[7:5] == `VCC_OP3_FLAG_CLR)
            clr = cmd[4:0];
        else
            clr = 5'h00;
    end

    // next state
    always_comb begin
        st_nxt = st_r;
        st_nxt.mr_pulse = 1'b0;
        st_nxt.lg_strobe = 1'b0;

        // write address and data may arrive in either order
        if (s_axi_awvalid && s_axi_awready) begin
            st_nxt.aw_got = 1'b1;
            st_nxt.waddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            st_nxt.w_got = 1'b1;
            st_nxt.wdata = s_axi_wdata[7:0];
            st_nxt.wlane0 = s_axi_wstrb[0];
        end
        if (st_r.bvalid && s_axi_bready)
            st_nxt.bvalid = 1'b0;
        if (do_wr) begin
            st_nxt.aw_got = 1'b0;
            st_nxt.w_got = 1'b0;
            st_nxt.bvalid = 1'b1;
            st_nxt.bresp = addr_known(st_r.waddr) ? `VCC_RESP_OKAY
                                                  : `VCC_RESP_SLVERR;
        end

        // data registers; only byte lane 0 carries data
        if (do_wr && st_r.wlane0) begin
            case (st_r.waddr)
                `VCC_A_CUR_HI: st_nxt.cur_hi = cmd[5:0];
                `VCC_A_CUR_LO: st_nxt.cur_lo = cmd;
                `VCC_A_PRS_HI: begin
                    st_nxt.prs_hi = cmd[5:0];
                    if (init_word_zero_bit7)
                        st_nxt.row_size = cmd[7:6];
                end
                `VCC_A_PRS_LO: st_nxt.prs_lo = cmd;
                `VCC_A_SRS_HI: begin
                    st_nxt.srs_hi = cmd[5:0];
                    st_nxt.split_b_reload = cmd[`VCC_B_SPLIT_B_RELOAD];
                    st_nxt.split_a_reload = cmd[`VCC_B_SPLIT_A_RELOAD];
                end
                `VCC_A_SRS_LO: st_nxt.srs_lo = cmd;
                default: ;
            endcase
        end

        // command decode, acted on as the write completes
        if (cmd_fire) begin
            if (mr_fire) begin
                st_nxt.mr_pulse = 1'b1;
                st_nxt.mask = 5'h00;
                st_nxt.pointer = 4'h0;
                st_nxt.gfx_req = 1'b0;
                st_nxt.gfx_active = 1'b0;
                st_nxt.cursor_en = 1'b0;
                st_nxt.blank_force = 1'b1;
                st_nxt.resume_pend = 1'b0;
                st_nxt.mr_count = (st_r.mr_count == 2'h0) ? 2'h1 : 2'h2;
            end else begin
                st_nxt.mr_count = 2'h0; // reset pair must be back to back
                case (cmd[7:5])
                    3'h0: begin
                        // values above 14 are ignored
                        if (cmd[4] && cmd[3:0] <= `VCC_PTR_MAX)
                            st_nxt.pointer = cmd[3:0];
                    end
                    `VCC_OP3_MODE: begin
                        // any mix of graphics, display, cursor is allowed
                        if (cmd[`VCC_B_CMD_GFX])
                            st_nxt.gfx_req = cmd[`VCC_B_CMD_ON];
                        if (cmd[`VCC_B_CMD_DSP]) begin
                            if (cmd[`VCC_B_CMD_ON]) begin
                                st_nxt.addr_oe = 1'b1;
                                st_nxt.resume_pend = 1'b1;
                                st_nxt.resume_field = cmd[`VCC_B_CMD_N];
                            end else begin
                                st_nxt.blank_force = 1'b1;
                                st_nxt.resume_pend = 1'b0;
                                if (cmd[`VCC_B_CMD_N])
                                    st_nxt.addr_oe = 1'b0;
                            end
                        end
                        if (cmd[`VCC_B_CMD_CUR])
                            st_nxt.cursor_en = cmd[`VCC_B_CMD_ON];
                    end
                    `VCC_OP3_INT_EN:
                        st_nxt.mask = st_r.mask | cmd[4:0];
                    `VCC_OP3_INT_DIS: st_nxt.mask = st_r.mask & ~cmd[4:0];
                    `VCC_OP3_DELAYED: st_nxt.idle = 1'b0;
                    default: ;
                endcase
            end
        end
        if (st_r.mr_count == 2'h2)
            st_nxt.por_released = 1'b1;

        // sticky flags, a new event wins over a clear in the same cycle
        st_nxt.raw = (st_r.raw & ~clr) | ev;
        st_nxt.masked = (st_r.masked & ~clr)
                        | (ev & st_nxt.mask);
        if (mr_fire)
            st_nxt.idle = 1'b1;
        if (delayed_done)
            st_nxt.idle = 1'b1;

        // graphics addressing switches on row boundaries; master reset stops it at once
        if (row_start)
            st_nxt.gfx_active = st_nxt.gfx_req;
        st_nxt.lg_strobe = st_r.gfx_active && blank_fall;

        // blanking released at the chosen boundary
        if (st_r.resume_pend &&
                (st_r.resume_field ? field_start : line_start)) begin
            st_nxt.resume_pend = 1'b0;
            st_nxt.blank_force = 1'b0;
        end

        // read path, data from a register
        if (st_r.rvalid && s_axi_rready)
            st_nxt.rvalid = 1'b0;
        if (s_axi_arvalid && s_axi_arready) begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rresp = addr_known(s_axi_araddr) ? `VCC_RESP_OKAY
                                                    : `VCC_RESP_SLVERR;
            case (s_axi_araddr)
                `VCC_A_CUR_HI: st_nxt.rdata = {26'h0, st_r.cur_hi};
                `VCC_A_CUR_LO: st_nxt.rdata = {24'h0, st_r.cur_lo};
                `VCC_A_PRS_HI: st_nxt.rdata = {26'h0, st_r.prs_hi};
                `VCC_A_PRS_LO: st_nxt.rdata = {24'h0, st_r.prs_lo};
                // reload bits are write only
                `VCC_A_SRS_HI:
                    st_nxt.rdata = {26'h0, st_r.srs_hi};
                `VCC_A_SRS_LO: st_nxt.rdata = {24'h0, st_r.srs_lo};
                `VCC_A_EV_MASKED: st_nxt.rdata = {27'h0, st_r.masked};
                `VCC_A_EV_RAW:
                    st_nxt.rdata = {26'h0, st_r.idle, st_r.raw};
                `VCC_A_MODE:
                    st_nxt.rdata = {17'h0, st_r.mask, st_r.pointer,
                                    st_r.gfx_req, st_r.gfx_active,
                                    st_r.cursor_en, st_r.blank_force,
                                    st_r.addr_oe, st_r.por_released};
                default: st_nxt.rdata = 32'h0;
            endcase
        end

        // synchronous reset: power-up state
        if (!aresetn) begin
            st_nxt = '0;
            st_nxt.idle = 1'b1;
            st_nxt.blank_force = 1'b1;
            st_nxt.addr_oe = 1'b1;
        end
    end

    // state register
    always_ff @(posedge aclk) begin
        st_r <= st_nxt;
    end

    // outputs, all from the state word
    assign s_axi_bvalid = st_r.bvalid;
    assign s_axi_bresp = st_r.bresp;
    assign s_axi_rvalid = st_r.rvalid;
    assign s_axi_rresp = st_r.rresp;
    assign s_axi_rdata = st_r.rdata;
    assign host_interrupt_out = |st_r.masked;
    assign blank_force = st_r.blank_force;
    // syncs held low while reset runs or before the power-on release
    assign sync_hold_low = st_r.mr_pulse || !st_r.por_released;
    assign display_address_oe = st_r.addr_oe;
    assign cursor_enable = st_r.cursor_en;
    assign graphics_active = st_r.gfx_active;
    assign line_graphics_strobe = st_r.lg_strobe;
    assign init_word_pointer = st_r.pointer;
    assign init_word_two_clear = st_r.mr_pulse;
    assign row_size_attr_field = st_r.row_size;
    assign split_a_reload_enable = st_r.split_a_reload;
    assign split_b_reload_enable = st_r.split_b_reload;
    assign cursor_position = {st_r.cur_hi, st_r.cur_lo};
    assign primary_row_start = {st_r.prs_hi, st_r.prs_lo};
    assign secondary_row_start = {st_r.srs_hi, st_r.srs_lo};
    assign por_released = st_r.por_released;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_mreset;
        mr_fire && !delayed_done |=> st_r.idle && st_r.mask == 5'h00
            && st_r.blank_force && !st_r.cursor_en && st_r.pointer == 4'h0;
    endproperty
    a_mreset: assert property (p_mreset)
        else $error("master reset state wrong");

    property p_frame_blank_flag;
        frame_blank_flag_start |=> st_r.raw[4];
    endproperty
    a_frame_blank_flag: assert property (p_frame_blank_flag)
        else $error("blank flag not set");

    property p_line0;
        row_line0 |=> st_r.raw[3] ##1 st_r.raw[3] || $past(cmd_fire);
    endproperty
    a_line0: assert property (p_line0)
        else $error("line zero flag lost");

    property p_ready;
        delayed_done |=> st_r.raw[1] && st_r.idle;
    endproperty
    a_ready: assert property (p_ready)
        else $error("ready flag not set");

    property p_sticky;
        st_r.raw[2] && !cmd_fire |=> st_r.raw[2];
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("flag dropped without clear");

    property p_masked;
        !st_r.mask[4] && !st_r.masked[4] && !cmd_fire |=> !st_r.masked[4];
    endproperty
    a_masked: assert property (p_masked)
        else $error("masked event reached interrupt");

    property p_dspoff;
        cmd_fire && cmd[7:5] == `VCC_OP3_MODE && cmd[3] && !cmd[0]
            |=> blank_force [*2];
    endproperty
    a_dspoff: assert property (p_dspoff)
        else $error("display off did not blank");

    property p_cursor;
        cmd_fire && cmd[7:4] == 4'h3 && !cmd[0] |=> !cursor_enable;
    endproperty
    a_cursor: assert property (p_cursor)
        else $error("cursor not held off");

    property p_lg;
        blank_fall && st_r.gfx_active |=> line_graphics_strobe;
    endproperty
    a_lg: assert property (p_lg)
        else $error("graphics strobe missing");

    property p_split_b;
        row_line0 && scrolling
            && row_number == 7'(split_row_b_value + 7'h01) |=> st_r.raw[0];
    endproperty
    a_split_b: assert property (p_split_b)
        else $error("split B flag not set");

endmodule

// ---- bench/vcc_host.sv ----
/*
 * Host processor model: AXI4-Lite master with word read and write tasks.
 * Assumes one clock aclk; the slave may answer after any number of cycles.
 */
module vcc_host (
    // clock
    input wire logic aclk,
    // write channels
    output logic [7:0] s_axi_awaddr,
    output logic s_axi_awvalid,
    input wire logic s_axi_awready,
    output logic [31:0] s_axi_wdata,
    output logic [3:0] s_axi_wstrb,
    output logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    output logic s_axi_bready,
    // read channels
    output logic [7:0] s_axi_araddr,
    output logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    output logic s_axi_rready
);
    timeunit 1ns;
    timeprecision 100ps;

    // response ready held high: avoids toggling it between transfers
    initial begin
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 3'h0;
        s_axi_wstrb = 4'hF;
        s_axi_bready = 1'b1;
        s_axi_rready = 1'b1;
    end

    // one write; released lines show the inverse, not a stale value
    task automatic wr(input logic [7:0] a, input logic [7:0] d,
                      output logic [1:0] r);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awvalid <= 1'b0;
                s_axi_awaddr <= ~s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wvalid <= 1'b0;
                s_axi_wdata <= ~s_axi_wdata;
            end
        end while (!s_axi_bvalid);
        r = s_axi_bresp;
    endtask

    // one read
    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arvalid <= 1'b0;
                s_axi_araddr <= ~s_axi_araddr;
            end
        end while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
    endtask

    // two back-to-back master resets release the power-on circuit
    task automatic por_release;
        logic [1:0] r;
        wr(8'h00, 8'h00, r);
        wr(8'h00, 8'h00, r);
    endtask
endmodule

// ---- bench/vcc_top_tb.sv ----
/*
 * Self-checking bench of the command/status block.
 * Assumes vcc_top and the host model vcc_host; raster events are pulsed here.
 */
`include "vcc_map.svh"

module vcc_top_tb;
    timeunit 1ns;
    timeprecision 100ps;

    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready;
    // event pulses: done, blank fall, field, row, line, line0, frame_blank_flag
    logic [6:0] ev = 7'h00;
    logic [6:0] row_number = 7'h00, split_a = 7'h00, split_b = 7'h00;
    logic scrolling = 1'b0, wz7 = 1'b0;
    logic host_interrupt_out, blank_force, sync_hold_low, display_address_oe;
    logic cursor_enable, graphics_active, line_graphics_strobe;
    logic init_word_two_clear, split_a_reload_enable, split_b_reload_enable;
    logic por_released;
    logic [3:0] init_word_pointer;
    logic [1:0] row_size_attr_field;
    logic [13:0] cursor_position, primary_row_start, secondary_row_start;
    int fails = 0;
    int checked = 0;

    vcc_top i_vcc_top (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .frame_blank_flag_start(ev[0]),
        .row_line0(ev[1]), .line_start(ev[2]), .row_start(ev[3]),
        .field_start(ev[4]), .blank_fall(ev[5]), .delayed_done(ev[6]),
        .row_number, .scrolling, .init_word_zero_bit7(wz7),
        .split_row_a_value(split_a), .split_row_b_value(split_b),
        .host_interrupt_out, .blank_force, .sync_hold_low,
        .display_address_oe, .cursor_enable, .graphics_active,
        .line_graphics_strobe, .init_word_pointer, .init_word_two_clear,
        .row_size_attr_field, .split_a_reload_enable, .split_b_reload_enable,
        .cursor_position, .primary_row_start, .secondary_row_start,
        .por_released
    );

    vcc_host i_vcc_host (
        .aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready
    );

    // 100 MHz clock
    always #5 aclk = ~aclk;

    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        checked++;
        if (e !== g) begin
            fails++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic wrc(input logic [7:0] a, input logic [7:0] d,
                       input logic [1:0] er = `VCC_RESP_OKAY);
        logic [1:0] r;
        i_vcc_host.wr(a, d, r);
        chk($sformatf("bresp %h", a), {30'h0, er}, {30'h0, r});
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0] r;
        i_vcc_host.rd(a, d, r);
        chk($sformatf("reg %h", a), e, d);
    endtask

    // pulse lands at the next edge; outputs read back at the one after
    task automatic pulse(input logic [6:0] m);
        ev <= m;
        @(posedge aclk);
        ev <= 7'h00;
        @(posedge aclk);
    endtask

    task automatic t_power;
        chk("sync_hold", 1, sync_hold_low);
        rdc(`VCC_A_CUR_LO, 32'h0);
        i_vcc_host.por_release();
        repeat (2) @(posedge aclk);
        chk("por", 1, por_released);
        chk("sync_hold", 0, sync_hold_low);
        chk("blank", 1, blank_force);
        rdc(`VCC_A_EV_RAW, 32'h20);
    endtask

    task automatic t_regs;
        wz7 <= 1'b1;
        wrc(`VCC_A_CUR_HI, 8'hFF);
        rdc(`VCC_A_CUR_HI, 32'h3F);
        wrc(`VCC_A_CUR_LO, 8'hA5);
        chk("cursor", 32'h3FA5, {18'h0, cursor_position});
        wrc(`VCC_A_PRS_HI, 8'hC5);
        rdc(`VCC_A_PRS_HI, 32'h05);
        chk("size", 3, {30'h0, row_size_attr_field});
        chk("prs", 32'h0500, {18'h0, primary_row_start});
        wrc(`VCC_A_SRS_HI, 8'hC0);
        chk("reload", 3, {30'h0, split_b_reload_enable,
                          split_a_reload_enable});
        rdc(`VCC_A_SRS_HI, 32'h0);
        wrc(`VCC_A_SRS_HI, 8'h00);
        wrc(`VCC_A_SRS_LO, 8'h3C);
        chk("srs", 32'h3C, {18'h0, secondary_row_start});
        wrc(8'h40, 8'h12, `VCC_RESP_SLVERR);
        rdc(`VCC_A_CMD, 32'h0);
    endtask

    task automatic t_events;
        split_a <= 7'h09;
        split_b <= 7'h05;
        row_number <= 7'h09;
        wrc(`VCC_A_CMD, 8'h7F);
        pulse(7'h01);
        rdc(`VCC_A_EV_MASKED, 32'h10);
        chk("host_interrupt_out", 1, host_interrupt_out);
        wrc(`VCC_A_CMD, 8'h50);
        rdc(`VCC_A_EV_RAW, 32'h20);
        wrc(`VCC_A_CMD, 8'h88);
        pulse(7'h02);
        rdc(`VCC_A_EV_RAW, 32'h2C);
        rdc(`VCC_A_EV_MASKED, 32'h04);
        scrolling <= 1'b1;
        row_number <= 7'h05;
        pulse(7'h02);
        rdc(`VCC_A_EV_RAW, 32'h2C);
        row_number <= 7'h06;
        pulse(7'h02);
        repeat (20) @(posedge aclk);
        rdc(`VCC_A_EV_RAW, 32'h2D);
        wrc(`VCC_A_CMD, 8'h5F);
        rdc(`VCC_A_EV_RAW, 32'h20);
        chk("host_interrupt_out", 0, host_interrupt_out);
    endtask

    task automatic t_cmds;
        wrc(`VCC_A_CMD, 8'hA9);
        rdc(`VCC_A_EV_RAW, 32'h00);
        wrc(`VCC_A_CMD, 8'h31);
        rdc(`VCC_A_EV_RAW, 32'h00);
        chk("cursor_en", 1, cursor_enable);
        pulse(7'h40);
        rdc(`VCC_A_EV_RAW, 32'h22);
        rdc(`VCC_A_EV_MASKED, 32'h02);
        wrc(`VCC_A_CMD, 8'h30);
        chk("cursor_en", 0, cursor_enable);
        wrc(`VCC_A_CMD, 8'h2C);
        chk("addr_oe", 0, display_address_oe);
        wrc(`VCC_A_CMD, 8'h29);
        chk("addr_oe", 1, display_address_oe);
        chk("blank", 1, blank_force);
        pulse(7'h04);
        @(posedge aclk);
        chk("blank", 0, blank_force);
        wrc(`VCC_A_CMD, 8'h28);
        chk("addr_oe", 1, display_address_oe);
        wrc(`VCC_A_CMD, 8'h2D);
        pulse(7'h04);
        chk("blank", 1, blank_force);
        pulse(7'h10);
        chk("blank", 0, blank_force);
        wrc(`VCC_A_CMD, 8'h23);
        chk("gfx", 0, graphics_active);
        pulse(7'h08);
        chk("gfx", 1, graphics_active);
        pulse(7'h20);
        chk("strobe", 1, line_graphics_strobe);
        wrc(`VCC_A_CMD, 8'h1E);
        wrc(`VCC_A_CMD, 8'h1F);
        chk("pointer", 32'hE, {28'h0, init_word_pointer});
        wrc(`VCC_A_CMD, 8'h00);
        chk("iw2_clr", 1, init_word_two_clear);
        chk("sync_hold", 1, sync_hold_low);
        chk("pointer", 0, {28'h0, init_word_pointer});
        chk("blank", 1, blank_force);
        rdc(`VCC_A_EV_RAW, 32'h20);
        rdc(`VCC_A_MODE, 32'h07);
        chk("host_interrupt_out", 0, host_interrupt_out);
    endtask

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // main sequence, reset held two cycles
    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_power();
        t_regs();
        t_events();
        t_cmds();
        end_of_test();
    end

    // watchdog: the run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge aclk);
        fails++;
        end_of_test();
    end
endmodule
